// ===== hdl/pesu_pkg.sv
package pesu_pkg;
    // ==========================================================
    // Register offsets on the model-specific register port
    localparam logic [11:0] OVF_STATUS_ADDR = 12'h38e;
    localparam logic [11:0] GLOBAL_EN_ADDR = 12'h38f;
    localparam logic [11:0] OVF_CLEAR_ADDR = 12'h390;
    localparam logic [11:0] SAMPLE_EN_ADDR = 12'h3f1;
    localparam logic [11:0] CAPS_ADDR = 12'h3e0;
    localparam logic [11:0] EVTSEL0_ADDR = 12'h3e1;
    localparam logic [11:0] COUNTER0_ADDR = 12'h3e2;
    localparam logic [11:0] DS_BASE_ADDR = 12'h3e3;
    localparam logic [11:0] DS_INDEX_ADDR = 12'h3e4;
    localparam logic [11:0] DS_MAX_ADDR = 12'h3e5;
    localparam logic [11:0] DS_THRESH_ADDR = 12'h3e6;
    localparam logic [11:0] DS_RELOAD_ADDR = 12'h3e7;
    // ==========================================================
    // Field positions
    localparam int CTR0_BIT = 0;
    localparam int BUF_OVF_BIT = 62;
    localparam int EVTSEL_INT_BIT = 20;
    localparam int EVTSEL_EN_BIT = 22;
    localparam int CAP_TRAP_BIT = 6;
    localparam int CAP_SAVE_BIT = 7;
    localparam int CAP_FMT_LSB = 8;
    localparam int MISC_AVAIL_BIT = 7;
    localparam int MISC_UNAVAIL_BIT = 12;
    // ==========================================================
    // Constants of the unit
    localparam int COUNTER_W = 40;
    localparam logic [3:0] RECORD_LAYOUT = 4'h0;
    localparam logic [7:0] PERFMON_VERSION = 8'h02;
    localparam int RECORD_WORDS = 18;
    localparam logic [63:0] RECORD_BYTES = 64'h0000_0000_0000_0090;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] EVT_LOAD_MISS = 8'hcb;
    localparam logic [7:0] EVT_BR_MISPRED = 8'hc5;
    localparam logic [7:0] EVT_SIMD = 8'hc7;
    localparam logic [7:0] UMASK_SIMD = 8'h1f;
    localparam logic [7:0] EVT_INSTR = 8'hc0;
    localparam logic [7:0] EVT_X87 = 8'hc1;
    localparam logic [7:0] UMASK_X87 = 8'hfe;

    typedef enum logic [3:0] {
        PESU_IDLE = 4'b0001,
        PESU_CAPTURE = 4'b0010,
        PESU_BRANCH = 4'b0100,
        PESU_IRQ = 4'b1000
    } pesu_state_t;
endpackage : pesu_pkg

// ===== hdl/pesu_top.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Record FIFO between capture and memory writer
module pesu_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic do_wr;
    logic do_rd;

    assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule : pesu_fifo

// ==========================================================
// Precise event sampling unit on counter zero
module pesu_top #(
    parameter bit TRAP_LIKE = 1'b1
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Model-specific register port
    input wire logic MSR_REQ,
    input wire logic MSR_WE,
    input wire logic [11:0] MSR_ADDR,
    input wire logic [63:0] MSR_WDATA,
    output logic [63:0] MSR_RDATA,
    output logic MSR_ACK,
    output logic MSR_ERR,
    // Retirement events from the core
    input wire logic EVT_HIT,
    input wire logic EVT_RETIRED,
    input wire logic [7:0] EVT_CODE,
    input wire logic [7:0] EVT_UMASK,
    input wire logic INSN_DONE,
    output logic INSN_HOLD,
    // Architectural state read port
    output logic [4:0] ARCH_SEL,
    input wire logic [63:0] ARCH_WORD,
    // Branch-trace store sequencing
    input wire logic BTS_REQ,
    output logic BTS_GRANT,
    input wire logic BTS_DONE,
    // Debug-store memory writes
    output logic DS_WVALID,
    input wire logic DS_WREADY,
    output logic [63:0] DS_WADDR,
    output logic [63:0] DS_WDATA,
    // Miscellaneous
    input wire logic FREEZE_ON_INTERRUPT,
    output logic [63:0] MISC_FEATURE_ENABLES,
    output logic PERF_MONITOR_INTERRUPT
);
    typedef struct packed {
        pesu_pkg::pesu_state_t state;
        logic [63:0] status;
        logic [63:0] global_en;
        logic [63:0] sample_en;
        logic [63:0] evtsel0;
        logic [pesu_pkg::COUNTER_W-1:0] counter0;
        logic [63:0] ds_base;
        logic [63:0] ds_index;
        logic [63:0] ds_max;
        logic [63:0] ds_thresh;
        logic [63:0] ds_reload;
        logic pending;
        logic bts_seen;
        logic [4:0] word;
        logic [63:0] rdata;
        logic ack;
        logic err;
        logic irq;
    } pesu_regs_t;

    pesu_regs_t r_reg;
    pesu_regs_t r_next;
    logic [63:0] caps;
    logic fifo_ready;
    logic fifo_valid;
    logic [127:0] fifo_out;
    logic push;
    logic [63:0] push_addr;
    logic sel_ok;
    logic counting;
    logic armed;

    // Only events that the retirement tagging makes exact may be sampled
    function automatic logic pesu_precise_ok(input logic [7:0] code, input logic [7:0] umask);
        logic ok;
        ok = 1'b0;
        unique case (code)
            pesu_pkg::EVT_LOAD_MISS: ok = umask inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
            pesu_pkg::EVT_BR_MISPRED: ok = umask == 8'h00;
            pesu_pkg::EVT_SIMD: ok = umask == pesu_pkg::UMASK_SIMD;
            pesu_pkg::EVT_INSTR: ok = umask == 8'h00;
            pesu_pkg::EVT_X87: ok = umask == pesu_pkg::UMASK_X87;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : pesu_precise_ok

    // ==========================================================
    // Constant capability and feature words
    always_comb begin
        caps = '0;
        caps[pesu_pkg::CAP_TRAP_BIT] = TRAP_LIKE;
        caps[pesu_pkg::CAP_SAVE_BIT] = 1'b1;
        caps[pesu_pkg::CAP_FMT_LSB +: 4] = pesu_pkg::RECORD_LAYOUT;
        caps[63:56] = pesu_pkg::PERFMON_VERSION;
        MISC_FEATURE_ENABLES = '0;
        MISC_FEATURE_ENABLES[pesu_pkg::MISC_AVAIL_BIT] = 1'b1;
        MISC_FEATURE_ENABLES[pesu_pkg::MISC_UNAVAIL_BIT] = 1'b0;
    end

    assign sel_ok = pesu_precise_ok(r_reg.evtsel0[7:0], r_reg.evtsel0[15:8]);
    assign counting = r_reg.global_en[pesu_pkg::CTR0_BIT] && r_reg.evtsel0[pesu_pkg::EVTSEL_EN_BIT];
    assign armed = r_reg.sample_en[pesu_pkg::CTR0_BIT] && sel_ok;
    assign push_addr = r_reg.ds_base + r_reg.ds_index + {56'h0, r_reg.word, 3'b000};
    assign push = r_reg.state == pesu_pkg::PESU_CAPTURE && fifo_ready;
    assign ARCH_SEL = r_reg.word;
    // Fault-like capture stalls completion so the state precedes the sampled instruction
    assign INSN_HOLD = !TRAP_LIKE && r_reg.state == pesu_pkg::PESU_CAPTURE;
    assign BTS_GRANT = r_reg.state == pesu_pkg::PESU_BRANCH;
    assign DS_WVALID = fifo_valid;
    assign DS_WADDR = fifo_out[127:64];
    assign DS_WDATA = fifo_out[63:0];
    assign MSR_RDATA = r_reg.rdata;
    assign MSR_ACK = r_reg.ack;
    assign MSR_ERR = r_reg.err;
    assign PERF_MONITOR_INTERRUPT = r_reg.irq;

    pesu_fifo #(
        .WIDTH(128),
        .DEPTH(pesu_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst(RST),
        .in_valid(r_reg.state == pesu_pkg::PESU_CAPTURE),
        .in_ready(fifo_ready),
        .in_data({push_addr, ARCH_WORD}),
        .out_valid(fifo_valid),
        .out_ready(DS_WREADY),
        .out_data(fifo_out)
    );

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic wrap_pending;
        wrap_pending = 1'b0;
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.err = 1'b0;
        r_next.irq = 1'b0;
        if (BTS_REQ) begin
            r_next.bts_seen = 1'b1;
        end

        // Counting of tagged retirements only
        if (counting && EVT_HIT && EVT_RETIRED && EVT_CODE == r_reg.evtsel0[7:0]
                && EVT_UMASK == r_reg.evtsel0[15:8]) begin
            r_next.counter0 = r_reg.counter0 + 1'b1;
            if (&r_reg.counter0) begin
                r_next.status[pesu_pkg::CTR0_BIT] = 1'b1;
                if (armed) begin
                    r_next.pending = 1'b1;
                    wrap_pending = 1'b1;
                end else if (r_reg.evtsel0[pesu_pkg::EVTSEL_INT_BIT]) begin
                    r_next.irq = 1'b1;
                end
            end
        end

        unique case (r_reg.state)
            pesu_pkg::PESU_IDLE: begin
                // Trap-like waits for the next eventing instruction to finish
                if (r_reg.pending && armed && EVT_HIT && EVT_RETIRED
                        && (!TRAP_LIKE || INSN_DONE)) begin
                    r_next.state = pesu_pkg::PESU_CAPTURE;
                    r_next.word = '0;
                    // A wrap in the launch cycle must not be lost: it arms the next sample
                    r_next.pending = wrap_pending;
                end
            end
            pesu_pkg::PESU_CAPTURE: begin
                if (r_reg.ds_index >= r_reg.ds_max) begin
                    // Buffer full: record dropped, but word 0 is still pushed into the FIFO for address ds_base + ds_index
                    r_next.state = pesu_pkg::PESU_BRANCH;
                end else if (push) begin
                    r_next.word = r_reg.word + 1'b1;
                    if (r_reg.word == 5'(pesu_pkg::RECORD_WORDS - 1)) begin
                        r_next.state = pesu_pkg::PESU_BRANCH;
                        r_next.ds_index = r_reg.ds_index + pesu_pkg::RECORD_BYTES;
                        r_next.counter0 = r_reg.ds_reload[pesu_pkg::COUNTER_W-1:0];
                        r_next.status[pesu_pkg::CTR0_BIT] = 1'b0;
                        r_next.status[pesu_pkg::BUF_OVF_BIT] = 1'b1;
                    end
                end
            end
            pesu_pkg::PESU_BRANCH: begin
                // Branch-trace record may only follow the finished sample
                if (!r_reg.bts_seen && !BTS_REQ || BTS_DONE) begin
                    r_next.bts_seen = 1'b0;
                    r_next.state = pesu_pkg::PESU_IRQ;
                end
            end
            pesu_pkg::PESU_IRQ: begin
                r_next.state = pesu_pkg::PESU_IDLE;
                if (r_reg.ds_index >= r_reg.ds_thresh) begin
                    r_next.irq = 1'b1;
                    if (FREEZE_ON_INTERRUPT) begin
                        r_next.global_en = '0;
                    end
                end
            end
        endcase

        // Register port; writes land after hardware updates so software wins only
        // where it owns the field, while overflow clear never hides a new overflow on a bit that was still clear before this cycle
        if (MSR_REQ) begin
            r_next.ack = 1'b1;
            r_next.rdata = '0;
            unique case (MSR_ADDR)
                pesu_pkg::OVF_STATUS_ADDR: begin
                    r_next.rdata = r_reg.status;
                    r_next.err = MSR_WE;
                end
                pesu_pkg::GLOBAL_EN_ADDR: begin
                    r_next.rdata = r_reg.global_en;
                    if (MSR_WE) begin
                        r_next.global_en = MSR_WDATA;
                    end
                end
                pesu_pkg::OVF_CLEAR_ADDR: begin
                    if (MSR_WE) begin
                        r_next.status = r_next.status & ~(MSR_WDATA & r_reg.status);
                    end
                end
                pesu_pkg::SAMPLE_EN_ADDR: begin
                    r_next.rdata = r_reg.sample_en;
                    if (MSR_WE) begin
                        r_next.sample_en = {63'h0, MSR_WDATA[pesu_pkg::CTR0_BIT]};
                    end
                end
                pesu_pkg::CAPS_ADDR: begin
                    r_next.rdata = caps;
                    r_next.err = MSR_WE;
                end
                pesu_pkg::EVTSEL0_ADDR: begin
                    r_next.rdata = r_reg.evtsel0;
                    if (MSR_WE) begin
                        r_next.evtsel0 = MSR_WDATA;
                    end
                end
                pesu_pkg::COUNTER0_ADDR: begin
                    r_next.rdata = {24'h0, r_reg.counter0};
                    if (MSR_WE) begin
                        r_next.counter0 = MSR_WDATA[pesu_pkg::COUNTER_W-1:0];
                    end
                end
                pesu_pkg::DS_BASE_ADDR: begin
                    r_next.rdata = r_reg.ds_base;
                    if (MSR_WE) begin
                        r_next.ds_base = MSR_WDATA;
                    end
                end
                pesu_pkg::DS_INDEX_ADDR: begin
                    r_next.rdata = r_reg.ds_index;
                    if (MSR_WE) begin
                        r_next.ds_index = MSR_WDATA;
                    end
                end
                pesu_pkg::DS_MAX_ADDR: begin
                    r_next.rdata = r_reg.ds_max;
                    if (MSR_WE) begin
                        r_next.ds_max = MSR_WDATA;
                    end
                end
                pesu_pkg::DS_THRESH_ADDR: begin
                    r_next.rdata = r_reg.ds_thresh;
                    if (MSR_WE) begin
                        r_next.ds_thresh = MSR_WDATA;
                    end
                end
                pesu_pkg::DS_RELOAD_ADDR: begin
                    r_next.rdata = r_reg.ds_reload;
                    if (MSR_WE) begin
                        r_next.ds_reload = MSR_WDATA;
                    end
                end
                default: begin
                    r_next.err = 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            r_reg <= '0;
            r_reg.state <= pesu_pkg::PESU_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule : pesu_top

`default_nettype wire

// ===== bench/pesu_monitor.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Port checker for the sampling unit
module pesu_monitor #(
    parameter bit TRAP_LIKE = 1'b1
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic MSR_REQ,
    input wire logic MSR_WE,
    input wire logic [11:0] MSR_ADDR,
    input wire logic [63:0] MSR_RDATA,
    input wire logic MSR_ACK,
    input wire logic MSR_ERR,
    // Core and memory side
    input wire logic INSN_HOLD,
    input wire logic [4:0] ARCH_SEL,
    input wire logic BTS_GRANT,
    input wire logic DS_WVALID,
    input wire logic DS_WREADY,
    input wire logic [63:0] DS_WADDR,
    input wire logic [63:0] DS_WDATA,
    input wire logic [63:0] MISC_FEATURE_ENABLES,
    input wire logic PERF_MONITOR_INTERRUPT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    a_ack_next: assert property (MSR_REQ |=> MSR_ACK)
        else $error("no acknowledge after request");
    a_err_unmapped: assert property (MSR_REQ && !(MSR_ADDR inside {[12'h38e:12'h390], 12'h3f1, [12'h3e0:12'h3e7]})
        |=> MSR_ERR && MSR_RDATA == 64'h0)
        else $error("unmapped access not refused");
    a_caps_fields: assert property (MSR_REQ && !MSR_WE && MSR_ADDR == 12'h3e0
        |=> MSR_RDATA[11:6] == {4'h0, 1'b1, TRAP_LIKE} && MSR_RDATA[63:56] >= 8'h02)
        else $error("capability fields wrong");
    a_misc_bits: assert property (MISC_FEATURE_ENABLES[7] && !MISC_FEATURE_ENABLES[12])
        else $error("availability bits wrong");
    a_irq_pulse: assert property (PERF_MONITOR_INTERRUPT |=> !PERF_MONITOR_INTERRUPT)
        else $error("interrupt longer than one cycle");
    a_irq_held: assert property (PERF_MONITOR_INTERRUPT |-> !BTS_GRANT && !$past(BTS_GRANT))
        else $error("interrupt during branch trace");
    a_bts_after_rec: assert property ($rose(BTS_GRANT) |-> $past(ARCH_SEL) == 5'h11)
        else $error("branch trace before record end");
    a_ds_hold: assert property (DS_WVALID && !DS_WREADY |=> DS_WVALID && $stable(DS_WADDR) && $stable(DS_WDATA))
        else $error("record word changed under stall");
    a_word_align: assert property (DS_WVALID |-> DS_WADDR[2:0] == 3'h0)
        else $error("record word not 64-bit aligned");
    a_trap_no_hold: assert property (!TRAP_LIKE || !INSN_HOLD)
        else $error("completion held in trap-like mode");

    c_irq: cover property (PERF_MONITOR_INTERRUPT);
    c_stall: cover property (DS_WVALID && !DS_WREADY);
    c_grant: cover property ($rose(BTS_GRANT));
    c_err: cover property (MSR_ERR);
endmodule : pesu_monitor

bind pesu_top pesu_monitor #(.TRAP_LIKE(TRAP_LIKE)) pesu_monitor_inst (.CLK(CLK), .RST(RST), .MSR_REQ(MSR_REQ),
    .MSR_WE(MSR_WE), .MSR_ADDR(MSR_ADDR), .MSR_RDATA(MSR_RDATA), .MSR_ACK(MSR_ACK), .MSR_ERR(MSR_ERR),
    .INSN_HOLD(INSN_HOLD), .ARCH_SEL(ARCH_SEL), .BTS_GRANT(BTS_GRANT), .DS_WVALID(DS_WVALID),
    .DS_WREADY(DS_WREADY), .DS_WADDR(DS_WADDR), .DS_WDATA(DS_WDATA),
    .MISC_FEATURE_ENABLES(MISC_FEATURE_ENABLES), .PERF_MONITOR_INTERRUPT(PERF_MONITOR_INTERRUPT));
`default_nettype wire

// ===== bench/pesu_ds_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Debug-store memory and architectural state source
module pesu_ds_model (
    // Clock
    input wire logic clk,
    // Stall control
    input wire logic slow,
    // Record word writes
    input wire logic ds_wvalid,
    output logic ds_wready,
    input wire logic [63:0] ds_waddr,
    input wire logic [63:0] ds_wdata,
    // Architectural state port
    input wire logic [4:0] arch_sel,
    output logic [63:0] arch_word
);
    logic [63:0] mem_addr [0:31];
    logic [63:0] mem_data [0:31];
    int count = 0;
    int tick = 0;

    // Each slot carries its index so a misplaced word shows up
    assign arch_word = 64'h5a5a_0000_0000_0000 + 64'(arch_sel);

    initial ds_wready = 1'b0;

    // Slow mode takes one word in eight so the record FIFO backs up
    always @(posedge clk) begin
        if (ds_wvalid && ds_wready && count < 32) begin
            mem_addr[count] = ds_waddr;
            mem_data[count] = ds_wdata;
            count++;
        end
        tick++;
        ds_wready <= #1 !slow || tick % 8 == 0;
    end
endmodule : pesu_ds_model
`default_nettype wire

// ===== bench/pesu_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Self-checking bench for the sampling unit
module pesu_top_tb;
    logic clk, rst, req, we, ack, err, e, hit, ret, done, hold, bts_req, grant, bts_done;
    logic wvalid, wready, freeze, irq, slow, hold2;
    logic [11:0] addr;
    logic [7:0] code, umask;
    logic [4:0] sel;
    logic [63:0] wdata, rdata, word, waddr, wword, misc, q;
    logic [15:0] evtab [0:6];
    int bad_count, comparisons, irq_count;

    pesu_top pesu_top_inst (.CLK(clk), .RST(rst), .MSR_REQ(req), .MSR_WE(we), .MSR_ADDR(addr),
        .MSR_WDATA(wdata), .MSR_RDATA(rdata), .MSR_ACK(ack), .MSR_ERR(err), .EVT_HIT(hit),
        .EVT_RETIRED(ret), .EVT_CODE(code), .EVT_UMASK(umask), .INSN_DONE(done), .INSN_HOLD(hold),
        .ARCH_SEL(sel), .ARCH_WORD(word), .BTS_REQ(bts_req), .BTS_GRANT(grant), .BTS_DONE(bts_done),
        .DS_WVALID(wvalid), .DS_WREADY(wready), .DS_WADDR(waddr), .DS_WDATA(wword),
        .FREEZE_ON_INTERRUPT(freeze), .MISC_FEATURE_ENABLES(misc), .PERF_MONITOR_INTERRUPT(irq));
    pesu_ds_model pesu_ds_model_inst (.clk(clk), .slow(slow), .ds_wvalid(wvalid), .ds_wready(wready),
        .ds_waddr(waddr), .ds_wdata(wword), .arch_sel(sel), .arch_word(word));
    // Fault-like copy shares all stimulus; only its completion hold is judged
    pesu_top #(.TRAP_LIKE(1'b0)) pesu_top_fault_inst (.CLK(clk), .RST(rst), .MSR_REQ(req), .MSR_WE(we),
        .MSR_ADDR(addr), .MSR_WDATA(wdata), .MSR_RDATA(), .MSR_ACK(), .MSR_ERR(), .EVT_HIT(hit),
        .EVT_RETIRED(ret), .EVT_CODE(code), .EVT_UMASK(umask), .INSN_DONE(done), .INSN_HOLD(hold2),
        .ARCH_SEL(), .ARCH_WORD(word), .BTS_REQ(bts_req), .BTS_GRANT(), .BTS_DONE(bts_done),
        .DS_WVALID(), .DS_WREADY(wready), .DS_WADDR(), .DS_WDATA(), .FREEZE_ON_INTERRUPT(freeze),
        .MISC_FEATURE_ENABLES(), .PERF_MONITOR_INTERRUPT());

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (irq === 1'b1) begin
            irq_count++;
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request is a one-cycle pulse; answer is sampled in the following cycle
    task automatic msr(input logic w, input logic [11:0] a, input logic [63:0] d);
        req = 1'b1;
        we = w;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        req = 1'b0;
        chk(ack, 1'b1);
        q = rdata;
        e = err;
        @(posedge clk);
        #1;
    endtask : msr

    task automatic wr(input logic [11:0] a, input logic [63:0] d);
        msr(1'b1, a, d);
        chk(e, 1'b0);
    endtask : wr

    task automatic ev(input logic r, input logic dn);
        hit = 1'b1;
        ret = r;
        done = dn;
        @(posedge clk);
        #1;
        hit = 1'b0;
        ret = 1'b0;
        done = 1'b0;
        @(posedge clk);
        #1;
    endtask : ev

    task automatic t_regs;
        msr(1'b0, 12'h3e0, 64'h0);
        chk(q[11:6], 6'h03);
        chk(q[63:56], 8'h02);
        chk({misc[12], misc[7]}, 2'h1);
        wr(12'h3f1, '1);
        msr(1'b0, 12'h3f1, 64'h0);
        chk(q, 64'h1);
        wr(12'h3f1, 64'h0);
        msr(1'b0, 12'h3f1, 64'h0);
        chk(q, 64'h0);
        msr(1'b1, 12'h38e, '1);
        chk(e, 1'b1);
        msr(1'b1, 12'h3e0, '1);
        chk(e, 1'b1);
        msr(1'b0, 12'h123, 64'h0);
        chk(e, 1'b1);
        $display("register test done");
    endtask : t_regs

    task automatic t_count;
        int i0;
        code = 8'h3c;
        umask = 8'h00;
        wr(12'h38f, 64'h0);
        msr(1'b0, 12'h38e, 64'h0);
        wr(12'h390, '1);
        wr(12'h3f1, 64'h1);
        wr(12'h3e2, 64'hff_ffff_ffff);
        wr(12'h3e1, 64'h50_003c);
        wr(12'h38f, 64'h1);
        i0 = irq_count;
        ev(1'b0, 1'b1);
        msr(1'b0, 12'h3e2, 64'h0);
        chk(q, 64'hff_ffff_ffff);
        ev(1'b1, 1'b1);
        repeat (30) @(posedge clk);
        #1;
        chk(irq_count - i0, 1);
        chk(pesu_ds_model_inst.count, 0);
        msr(1'b0, 12'h38e, 64'h0);
        chk(q[0], 1'b1);
        wr(12'h390, 64'h1);
        msr(1'b0, 12'h38e, 64'h0);
        chk(q[0], 1'b0);
        $display("count test done");
    endtask : t_count

    task automatic t_sample(input int k);
        int i0;
        freeze = k[0];
        slow = k[1];
        {umask, code} = evtab[k];
        wr(12'h38f, 64'h0);
        wr(12'h390, '1);
        wr(12'h3e3, 64'h1000);
        wr(12'h3e4, 64'h0);
        wr(12'h3e5, 64'h1000);
        wr(12'h3e6, 64'h90);
        wr(12'h3e7, 64'hff_ffff_fff0);
        wr(12'h3e2, 64'hff_ffff_ffff);
        wr(12'h3e1, {40'h0, 8'h40, evtab[k]});
        wr(12'h3f1, 64'h1);
        wr(12'h38f, 64'h1);
        pesu_ds_model_inst.count = 0;
        i0 = irq_count;
        ev(1'b1, 1'b0);
        ev(1'b1, 1'b0);
        chk(hold2, 1'b1);
        repeat (4) @(posedge clk);
        #1;
        chk(pesu_ds_model_inst.count, 0);
        bts_req = 1'b1;
        ev(1'b1, 1'b1);
        chk(hold, 1'b0);
        for (int n = 0; n < 200 && grant !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(grant, 1'b1);
        repeat (8) @(posedge clk);
        #1;
        chk(irq_count - i0, 0);
        bts_done = 1'b1;
        bts_req = 1'b0;
        @(posedge clk);
        #1;
        bts_done = 1'b0;
        repeat (200) @(posedge clk);
        #1;
        chk(irq_count - i0, 1);
        chk(hold2, 1'b0);
        chk(pesu_ds_model_inst.count, 18);
        for (int i = 0; i < 18; i++) begin
            chk(pesu_ds_model_inst.mem_addr[i], 64'h1000 + 8 * i);
            chk(pesu_ds_model_inst.mem_data[i], 64'h5a5a_0000_0000_0000 + i);
        end
        msr(1'b0, 12'h3e4, 64'h0);
        chk(q, 64'h90);
        msr(1'b0, 12'h3e2, 64'h0);
        chk(q, 64'hff_ffff_fff0);
        msr(1'b0, 12'h38e, 64'h0);
        chk({q[62], q[0]}, 2'h2);
        msr(1'b0, 12'h38f, 64'h0);
        chk(q, {63'h0, !freeze});
        $display("sample test %0d done", k);
    endtask : t_sample

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        rst = 1'b1;
        req = 1'b0;
        we = 1'b0;
        addr = 12'h000;
        wdata = 64'h0;
        hit = 1'b0;
        ret = 1'b0;
        done = 1'b0;
        code = 8'h00;
        umask = 8'h00;
        bts_req = 1'b0;
        bts_done = 1'b0;
        freeze = 1'b0;
        slow = 1'b0;
        bad_count = 0;
        comparisons = 0;
        irq_count = 0;
        evtab = '{16'h01cb, 16'h02cb, 16'h04cb, 16'h08cb, 16'h10cb, 16'h00c5, 16'h1fc7};
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        t_regs();
        t_count();
        for (int k = 0; k < 7; k++) begin
            t_sample(k);
        end
        conclude();
    end

    // Whole run needs a few thousand cycles
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule : pesu_top_tb
`default_nettype wire
